// >>> rtl/incr_or_exec.v
`timescale 1ns/100ps
`default_nettype none
`include "incr_or_exec_map.vh"

module incr_or_exec (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Instruction stream
  input wire instr_valid,
  input wire [11:0] instr,
  // File register read data for the addressed register
  input wire [7:0] freg_rdata,
  // File register write back
  output reg freg_we_r,
  output reg [4:0] freg_addr_r,
  output reg [7:0] freg_wdata_r,
  // Core state
  output reg [7:0] accum_r,
  output reg zflag_r,
  output reg stall_r,
  output reg skip_r
);

  // Opcode match under a mask; every decode goes through this one test
  function op_match;
    input [11:0] word;
    input [11:0] mask;
    input [11:0] pattern;
    begin
      op_match = ((word & mask) == pattern);
    end
  endfunction

  // Eight-bit increment; the carry out of bit 7 is dropped, so all ones wraps to zero
  function [7:0] inc8;
    input [7:0] value;
    reg [8:0] sum;
    begin
      sum = {1'b0, value} + 9'h001;
      inc8 = sum[7:0];
    end
  endfunction

  // Zero test shared by the flag update and the skip decision
  function is_zero8;
    input [7:0] value;
    begin
      is_zero8 = (value == 8'h00);
    end
  endfunction

  // Issue qualification
  wire busy;
  wire go;
  // A taken skip or the second cycle of a jump makes the block busy for one cycle
  assign busy = stall_r | skip_r;
  // A word offered in a dead cycle is dropped, not held; the fetch side must not count on a retry
  assign go = instr_valid & ~busy;

  // Instruction fields
  wire dbit;
  wire [4:0] faddr;
  wire [7:0] literal;
  assign dbit = instr[`INSTR_DEST_BIT];
  assign faddr = instr[`INSTR_FADDR_MSB:0];
  assign literal = instr[`INSTR_LIT_MSB:0];

  // Opcode decode; the patterns do not overlap, so at most one line is high
  wire dec_inc;
  wire dec_incsz;
  wire dec_accum_or_reg_op;
  wire dec_literal_or_accum_op;
  wire dec_jump;
  assign dec_inc = go & op_match(instr, `OPC_INC_MASK, `OPC_INC);
  assign dec_incsz = go & op_match(instr, `OPC_INC_MASK, `OPC_INCSZ);
  assign dec_accum_or_reg_op = go & op_match(instr, `OPC_INC_MASK, `OPC_ACCUM_OR_REG_OP);
  assign dec_literal_or_accum_op = go & op_match(instr, `OPC_LIT_MASK, `OPC_LITERAL_OR_ACCUM_OP);
  assign dec_jump = go & op_match(instr, `OPC_JMP_MASK, `OPC_JMP);

  // Operands are formed for every word and selected below
  // Both OR forms read the accumulator as it stood before this edge
  wire [7:0] inc_sum;
  wire [7:0] or_reg;
  wire [7:0] or_lit;
  wire inc_zero;
  assign inc_sum = inc8(freg_rdata);
  assign or_reg = accum_r | freg_rdata;
  assign or_lit = accum_r | literal;
  assign inc_zero = is_zero8(inc_sum);

  // Result source codes
  // SRC_NONE also covers ignored words and words that are not decoded here
  localparam [2:0] SRC_NONE = 3'h0;
  localparam [2:0] SRC_INC = 3'h1;
  localparam [2:0] SRC_INCSZ = 3'h2;
  localparam [2:0] SRC_ORREG = 3'h3;
  localparam [2:0] SRC_ORLIT = 3'h4;
  localparam [2:0] SRC_JUMP = 3'h5;

  reg [2:0] src;
  always @* begin
    src = SRC_NONE;
    if (dec_inc) begin
      src = SRC_INC;
    end else if (dec_incsz) begin
      src = SRC_INCSZ;
    end else if (dec_accum_or_reg_op) begin
      src = SRC_ORREG;
    end else if (dec_literal_or_accum_op) begin
      src = SRC_ORLIT;
    end else if (dec_jump) begin
      src = SRC_JUMP;
    end
  end

  // Result, destination and flag update for the selected source
  reg [7:0] result;
  reg hit;
  reg to_file;
  reg z_upd;
  always @* begin
    result = 8'h00;
    hit = 1'b0;
    to_file = 1'b0;
    z_upd = 1'b0;
    case (src)
      SRC_INC: begin
        result = inc_sum;
        hit = 1'b1;
        to_file = dbit;
        z_upd = 1'b1;
      end
      SRC_INCSZ: begin
        result = inc_sum;
        hit = 1'b1;
        to_file = dbit;
      end
      SRC_ORREG: begin
        result = or_reg;
        hit = 1'b1;
        to_file = dbit;
        z_upd = 1'b1;
      end
      SRC_ORLIT: begin
        result = or_lit;
        hit = 1'b1;
        z_upd = 1'b1;
      end
      SRC_JUMP: begin
        // Only the extra cycle belongs here; the target goes to the program counter logic
        result = 8'h00;
      end
      default: begin
        // No-operation and unknown words write nothing
        result = 8'h00;
      end
    endcase
  end

  // Next values of the registered outputs
  // Defaults hold accumulator and zero flag, so an ignored or unknown word changes neither
  reg [7:0] accum_nxt;
  reg zflag_nxt;
  reg freg_we_nxt;
  reg [4:0] freg_addr_nxt;
  reg [7:0] freg_wdata_nxt;
  reg stall_nxt;
  reg skip_nxt;
  always @* begin
    accum_nxt = accum_r;
    zflag_nxt = zflag_r;
    // Address and data follow every cycle; only the strobe says when they mean something
    freg_addr_nxt = faddr;
    freg_wdata_nxt = result;
    freg_we_nxt = hit & to_file;
    if (hit && !to_file) begin
      accum_nxt = result;
    end
    if (z_upd) begin
      zflag_nxt = is_zero8(result);
    end
    // The skip leaves the flags alone; only the slot after it becomes a no-operation
    skip_nxt = (src == SRC_INCSZ) & inc_zero;
    // Program counter loading is elsewhere; this block only spends the jump's second cycle
    stall_nxt = (src == SRC_JUMP);
  end

  // Accumulator and zero flag
  always @(posedge mclk) begin
    if (!rst_n) begin
      accum_r <= `ACCUM_RST;
      zflag_r <= `ZFLAG_RST;
    end else begin
      accum_r <= accum_nxt;
      zflag_r <= zflag_nxt;
    end
  end

  // File register write port; the strobe is high one cycle per write and stays high across back-to-back writes
  always @(posedge mclk) begin
    if (!rst_n) begin
      freg_we_r <= `FREG_WE_RST;
      freg_addr_r <= `FREG_ADDR_RST;
      freg_wdata_r <= `FREG_WDATA_RST;
    end else begin
      freg_we_r <= freg_we_nxt;
      freg_addr_r <= freg_addr_nxt;
      freg_wdata_r <= freg_wdata_nxt;
    end
  end

  // Dead-cycle markers after a jump or a taken skip
  always @(posedge mclk) begin
    if (!rst_n) begin
      stall_r <= `STALL_RST;
      skip_r <= `SKIP_RST;
    end else begin
      stall_r <= stall_nxt;
      skip_r <= skip_nxt;
    end
  end

endmodule // incr_or_exec
`default_nettype wire

// >>> rtl/incr_or_exec_map.vh
// Behaviour
// - Increment instruction adds one to the file register and sets zero flag.
// - Destination bit clear writes accumulator; set writes back to file register.
// - Increment-skip instruction increments to destination, leaves flags, skips on zero.
// - A skip replaces the prefetched instruction with a no-operation slot.
// - Literal-OR ORs the eight-bit immediate into the accumulator in one cycle.
// - Literal-OR result goes to accumulator and sets zero flag from it.
// - Unconditional jump takes two instruction cycles.
`ifndef INCR_OR_EXEC_MAP_VH
`define INCR_OR_EXEC_MAP_VH
`define OPC_INC_MASK 12'hfc0
`define OPC_INC 12'h280
`define OPC_INCSZ 12'h3c0
`define OPC_ACCUM_OR_REG_OP 12'h100
`define OPC_LIT_MASK 12'hf00
`define OPC_LITERAL_OR_ACCUM_OP 12'hd00
`define OPC_JMP_MASK 12'he00
`define OPC_JMP 12'ha00
`define OPC_NOP 12'h000
`define INSTR_DEST_BIT 5
`define INSTR_FADDR_MSB 4
`define ACCUM_RST 8'h00
`define ZFLAG_RST 1'b0
`define INSTR_LIT_MSB 7
`define FREG_WE_RST 1'b0
`define FREG_ADDR_RST 5'h00
`define FREG_WDATA_RST 8'h00
`define STALL_RST 1'b0
`define SKIP_RST 1'b0
`endif

// >>> test/incr_or_exec_properties.sv
`timescale 1ns/100ps
`default_nettype none
module incr_or_exec_properties(input wire logic mclk,rst_n,instr_valid,zflag_r,stall_r,skip_r,
  input wire logic [11:0] instr,input wire logic [7:0] freg_rdata,accum_r);
  wire t=rst_n&instr_valid&!stall_r&!skip_r;
  wire f=freg_rdata==8'hff;
  wire l=t&&instr[11:8]==4'hd;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_inc_zero: assert property(t&&instr[11:6]==6'h0a|=>zflag_r==$past(f))else $error("z");
  chk_skip_slot: assert property(t&&instr[11:6]==6'h0f|=>$stable(zflag_r)&&skip_r==$past(f))else $error("s");
  chk_lit_or: assert property(l|=>accum_r==($past(accum_r)|$past(instr[7:0])))else $error("o");
  chk_lit_zero: assert property(l|=>zflag_r==!accum_r)else $error("l");
  chk_jump_stall: assert property(t&&instr[11:9]==3'h5|=>stall_r)else $error("j");
  chk_reg_or: assert property(t&&instr[11:5]==7'h08|=>accum_r==($past(accum_r)|$past(freg_rdata)))else $error("r");
  cover property(skip_r);
  cover property(stall_r);
  cover property(l);
endmodule // incr_or_exec_properties
bind incr_or_exec incr_or_exec_properties u_chk(.*);
`default_nettype wire

// >>> test/test_incr_or_exec.sv
`timescale 1ns/100ps
`default_nettype none
module test_incr_or_exec;
reg mclk=0,rst_n=0,instr_valid=0;reg [11:0] instr=0;reg [7:0] freg_rdata=0;
wire freg_we_r,zflag_r,stall_r,skip_r;wire [7:0] accum_r,freg_wdata_r;wire [4:0] freg_addr_r;
integer seed=32'ha6a9,bad_count=0,total_checks=0,a=0,z=0,d=0,w=0,r,n,op;
incr_or_exec DUT(.*);
always #10 mclk=~mclk;
task check(input [13:0] s,e);begin total_checks++;if(s!==e)begin bad_count++;$display("Error %0t got %h want %h",$time,s,e);end end endtask
task complete_run;begin if(bad_count==0&&total_checks>0)$display("NO MISMATCHES");else $display("MISMATCHES SEEN");$finish;end endtask
initial begin #20000 bad_count++;complete_run;end
initial begin repeat(6)@(posedge mclk);#1 rst_n=1;
for(n=0;n<300;n++)begin op={$random(seed)}%5;
instr=(op==0?12'h280:op==1?12'h3c0:op==2?12'hd00:op==3?12'h100:12'ha00)|($random(seed)&(op==2?12'h0ff:12'h03f));
// Forced high nibble makes all-ones reads likely, so skips occur
freg_rdata=$random(seed)|(op<2?8'hf0:0);instr_valid=$random(seed);
@(posedge mclk);#1 r=(freg_rdata+1)%256;w=0;
if(d)d=0;else if(instr_valid)case(op)
0:begin z=r==0;w=instr[5];if(!w)a=r;end
1:begin d=r==0;w=instr[5];if(!w)a=r;end
2:begin a=a|instr[7:0];z=a==0;end
3:begin r=a|freg_rdata;z=r==0;w=instr[5];if(!w)a=r;end
4:d=1;
endcase
check({accum_r,zflag_r,stall_r|skip_r},{a[7:0],z[0],d[0]});
check({freg_we_r,w?{freg_addr_r,freg_wdata_r}:13'h0},{w[0],w?{instr[4:0],r[7:0]}:13'h0});
end complete_run;end
endmodule // test_incr_or_exec
`default_nettype wire
